/* rtl/ssei_pkg.sv */
// Package of constants and carriers for the status, event and interrupt block.
package ssei_pkg;

  // ==========================================================================
  // Register offsets on the serial register interface
  // ==========================================================================
  localparam logic [8:0] SSEI_ADDR_STATUS_IN  = 9'h050;
  localparam logic [8:0] SSEI_ADDR_STATUS_REG = 9'h051;
  localparam logic [8:0] SSEI_ADDR_EVENT_IN   = 9'h052;
  localparam logic [8:0] SSEI_ADDR_EVENT_REG  = 9'h053;
  localparam logic [8:0] SSEI_ADDR_MASK_IN    = 9'h054;
  localparam logic [8:0] SSEI_ADDR_MASK_REG   = 9'h055;
  localparam logic [8:0] SSEI_ADDR_CONTROL    = 9'h056;
  localparam logic [8:0] SSEI_LOCK_LO         = 9'h0d0;
  localparam logic [8:0] SSEI_LOCK_HI         = 9'h14f;

  // ==========================================================================
  // Field positions and implemented-bit masks
  // ==========================================================================
  localparam int         SSEI_POS_UVLO       = 6;
  localparam int         SSEI_POS_LOCK       = 7;
  localparam int         SSEI_POS_SLEW_B     = 5;
  localparam int         SSEI_POS_SLEW_A     = 3;
  localparam int         SSEI_POS_DEBOUNCE   = 0;
  localparam logic [7:0] SSEI_IN_EVT_BITS    = 8'h5f;
  localparam logic [7:0] SSEI_REG_EVT_BITS   = 8'h3f;
  localparam logic [7:0] SSEI_RST_MASK       = 8'h00;
  localparam logic [7:0] SSEI_RST_CONTROL    = 8'h00;
  localparam logic [8:0] SSEI_RST_COND       = 9'h006;

  // ==========================================================================
  // Timing: clock period, ramp step intervals and the debounce tick
  // ==========================================================================
  localparam int SSEI_CLK_NS       = 100;
  localparam int SSEI_STEP0_NS     = 4000;
  localparam int SSEI_STEP1_NS     = 2000;
  localparam int SSEI_STEP2_NS     = 1000;
  localparam int SSEI_STEP3_NS     = 500;
  localparam int SSEI_STEP0_CYC    = SSEI_STEP0_NS / SSEI_CLK_NS;
  localparam int SSEI_STEP1_CYC    = SSEI_STEP1_NS / SSEI_CLK_NS;
  localparam int SSEI_STEP2_CYC    = SSEI_STEP2_NS / SSEI_CLK_NS;
  localparam int SSEI_STEP3_CYC    = SSEI_STEP3_NS / SSEI_CLK_NS;
  localparam int SSEI_DEB_TICK_NS  = 100000;
  localparam int SSEI_DEB_TICK_CYC = SSEI_DEB_TICK_NS / SSEI_CLK_NS;
  // Debounce times in 0.1 ms ticks for codes 1 to 7.
  localparam logic [13:0] SSEI_DEB_T1 = 14'd1;
  localparam logic [13:0] SSEI_DEB_T2 = 14'd10;
  localparam logic [13:0] SSEI_DEB_T3 = 14'd100;
  localparam logic [13:0] SSEI_DEB_T4 = 14'd500;
  localparam logic [13:0] SSEI_DEB_T5 = 14'd2500;
  localparam logic [13:0] SSEI_DEB_T6 = 14'd5000;
  localparam logic [13:0] SSEI_DEB_T7 = 14'd10000;

  // ==========================================================================
  // Carriers
  // ==========================================================================
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [8:0] addr;
    logic [7:0] wdata;
  } ssei_req_s;

  typedef struct packed {
    logic ramp_busy_b;
    logic ramp_busy_a;
    logic current_limit_hit_b;
    logic current_limit_hit_a;
    logic thermal_shutdown_flag;
    logic thermal_warning_flag;
    logic output_in_range_b;
    logic output_in_range_a;
    logic io_supply_undervoltage;
  } ssei_cond_s;

  typedef struct packed {
    logic [8:0] addr;
    logic [7:0] data;
  } ssei_upper_wr_s;

endpackage

/* rtl/ssei_top.sv */
// Status, event latching, masking and interrupt logic with the lock/slew/debounce control register.
`timescale 1ns/100ps
`default_nettype none

// How it works
// [RL1] Status reads return present input levels; general inputs sit in bits 4..0.
// [RL2] Ramp-ready flags in status bits 7 and 6 are low while that buck ramps.
// [RL3] Over-current status bits 5 and 4 follow each buck's current limit.
// [RL4] Status bit 3 shows thermal shutdown level, bit 2 thermal warning level.
// [RL5] Power-good status bits 1 and 0 high only while output is in range.
// [RL6] Activation of an input, a rising fault flag or a power-good loss sets a sticky event bit until cleared.
// [RL7] Interrupt asserts while any unmasked event bit is set.
// [RL8] Host writes back the read value; each bit written one is cleared.
// [RL9] Events arriving during a clearing write are not lost; set beats clear.
// [RL10] Input event register: undervoltage bit 6, general inputs bits 4..0, polarity aware.
// [RL11] Regulator events: over-current 5..4, thermal 3..2, power-good loss 1..0.
// [RL12] Input mask register mirrors input event bits; set bit suppresses interrupt.
// [RL13] Regulator mask register bits 5..0 mirror the regulator event bits.
// [RL14] Lock bit 7 set makes writes to 0xD0 through 0x14F ignored.
// [RL15] Buck B ramp steps every 4.0, 2.0, 1.0 or 0.5 us per bits 6:5.
// [RL16] Buck A ramp steps on the same intervals selected by bits 4:3.
// [RL17] Three-bit field selects input debounce: none up to 1000 ms.
// [RL18] Input polarity bit 0 means active low, 1 means active high.
// [RL19] Interrupt drops once all unmasked events cleared; reserved bits read zero.
// [RL20] Pin and analogue inputs are synchronised before edge detection.
module ssei_top #(
  parameter int DEB_TICK_CYC = ssei_pkg::SSEI_DEB_TICK_CYC
) (
  // Clock, reset and enable
  input  wire logic                     clock,
  input  wire logic                     nrst,
  input  wire logic                     clk_en,
  // Register access from the serial interface
  input  wire ssei_pkg::ssei_req_s      reg_req,
  output var  logic [7:0]               reg_rdata_ff,
  // Monitored pins and analogue conditions
  input  wire logic [4:0]               general_input,
  input  wire ssei_pkg::ssei_cond_s     cond_in,
  input  wire logic [4:0]               input_polarity_select,
  // Interrupt to the host processor
  output var  logic                     interrupt_out_n_ff,
  // Upper register range write path and lock
  output var  logic                     upper_range_lock_ff,
  output var  logic                     upper_wr_pulse_ff,
  output var  ssei_pkg::ssei_upper_wr_s upper_wr_ff,
  // Ramp step strobes for the two bucks
  output var  logic [1:0]               ramp_step_tick_ff
);
  import ssei_pkg::*;

  localparam int NSYNC = 14;

  if (DEB_TICK_CYC < 2 || DEB_TICK_CYC > 16383) begin : g_chk
    $error("DEB_TICK_CYC out of range");
  end

  // ==========================================================================
  // Input synchronisers
  // ==========================================================================
  logic [NSYNC-1:0] raw;
  logic [NSYNC-1:0] s1_ff, s2_ff, s3_ff, lvl_ff;
  logic [NSYNC-1:0] nxt_lvl;
  assign raw = {cond_in, general_input};

  // A level counts only once the second and third stages agree.
  always_comb begin
    // [RL20] agreeing stages accepted
    nxt_lvl = lvl_ff;
    for (int i = 0; i < NSYNC; i++) begin
      if (s2_ff[i] == s3_ff[i]) begin
        nxt_lvl[i] = s3_ff[i];
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s1_ff  <= {SSEI_RST_COND, 5'h00};
      s2_ff  <= {SSEI_RST_COND, 5'h00};
      s3_ff  <= {SSEI_RST_COND, 5'h00};
      lvl_ff <= {SSEI_RST_COND, 5'h00};
    end else if (clk_en) begin
      s1_ff  <= raw;
      s2_ff  <= s1_ff;
      s3_ff  <= s2_ff;
      lvl_ff <= nxt_lvl;
    end
  end

  ssei_cond_s cond;
  assign cond = lvl_ff[NSYNC-1:5];

  // ==========================================================================
  // Register state: masks, control, events, read data
  // ==========================================================================
  logic [7:0] mask_in_ff, mask_reg_ff, ctrl_ff, evt_in_ff, evt_reg_ff;
  logic [7:0] nxt_mask_in, nxt_mask_reg, nxt_ctrl, nxt_evt_in, nxt_evt_reg, nxt_rdata;
  logic [7:0] status_in, status_reg, new_in, new_reg;
  logic [4:0] deb_ff;
  logic [4:0] act_prev_ff, nxt_act_prev, active;
  logic [8:0] cond_prev_ff;
  logic       nxt_irq_n, nxt_up_pulse, in_upper;
  logic [2:0] deb_code;
  ssei_upper_wr_s nxt_upper_wr;

  assign deb_code = ctrl_ff[SSEI_POS_DEBOUNCE +: 3];
  // [RL18] polarity applied
  assign active   = deb_ff ~^ input_polarity_select;
  assign in_upper = reg_req.addr >= SSEI_LOCK_LO && reg_req.addr <= SSEI_LOCK_HI;

  // Status images and new-event detection from the accepted levels.
  always_comb begin
    // [RL1] present input levels
    status_in  = {3'h0, deb_ff};
    // [RL2] ready low while ramping
    status_reg = {~cond.ramp_busy_b, ~cond.ramp_busy_a,
                  // [RL3] current limit levels
                  cond.current_limit_hit_b, cond.current_limit_hit_a,
                  // [RL4] thermal levels
                  cond.thermal_shutdown_flag, cond.thermal_warning_flag,
                  // [RL5] output range levels
                  cond.output_in_range_b, cond.output_in_range_a};
    nxt_act_prev = active;
    // [RL10] input event sources
    new_in = {1'b0, cond.io_supply_undervoltage & ~cond_prev_ff[0], 1'b0, active & ~act_prev_ff};
    // [RL11] regulator event sources
    new_reg = {2'h0,
               cond.current_limit_hit_b & ~cond_prev_ff[6],
               cond.current_limit_hit_a & ~cond_prev_ff[5],
               cond.thermal_shutdown_flag & ~cond_prev_ff[4],
               cond.thermal_warning_flag & ~cond_prev_ff[3],
               ~cond.output_in_range_b & cond_prev_ff[2],
               ~cond.output_in_range_a & cond_prev_ff[1]};
  end

  // Register writes, event latching, read mux and interrupt.
  always_comb begin
    nxt_mask_in  = mask_in_ff;
    nxt_mask_reg = mask_reg_ff;
    nxt_ctrl     = ctrl_ff;
    nxt_evt_in   = evt_in_ff;
    nxt_evt_reg  = evt_reg_ff;
    nxt_rdata    = reg_rdata_ff;
    nxt_up_pulse = 1'b0;
    if (reg_req.wr) begin
      case (reg_req.addr)
        // [RL8] write one clears
        SSEI_ADDR_EVENT_IN:  nxt_evt_in  = evt_in_ff & ~reg_req.wdata;
        SSEI_ADDR_EVENT_REG: nxt_evt_reg = evt_reg_ff & ~reg_req.wdata;
        // [RL12] input mask write
        SSEI_ADDR_MASK_IN:   nxt_mask_in = reg_req.wdata & SSEI_IN_EVT_BITS;
        // [RL13] regulator mask write
        SSEI_ADDR_MASK_REG:  nxt_mask_reg = reg_req.wdata & SSEI_REG_EVT_BITS;
        SSEI_ADDR_CONTROL:   nxt_ctrl = reg_req.wdata;
        default: begin
          // [RL14] locked range ignored
          nxt_up_pulse = in_upper && !ctrl_ff[SSEI_POS_LOCK];
        end
      endcase
    end
    nxt_upper_wr = nxt_up_pulse ? {reg_req.addr, reg_req.wdata} : upper_wr_ff;
    // [RL6] sticky event bits
    // [RL9] set wins over clear
    nxt_evt_in  = (nxt_evt_in | new_in) & SSEI_IN_EVT_BITS;
    nxt_evt_reg = (nxt_evt_reg | new_reg) & SSEI_REG_EVT_BITS;
    if (reg_req.rd) begin
      case (reg_req.addr)
        SSEI_ADDR_STATUS_IN:  nxt_rdata = status_in;
        SSEI_ADDR_STATUS_REG: nxt_rdata = status_reg;
        SSEI_ADDR_EVENT_IN:   nxt_rdata = evt_in_ff;
        SSEI_ADDR_EVENT_REG:  nxt_rdata = evt_reg_ff;
        SSEI_ADDR_MASK_IN:    nxt_rdata = mask_in_ff;
        SSEI_ADDR_MASK_REG:   nxt_rdata = mask_reg_ff;
        SSEI_ADDR_CONTROL:    nxt_rdata = ctrl_ff;
        // [RL19] unmapped reads zero
        default:              nxt_rdata = 8'h00;
      endcase
    end
    // [RL7] unmasked events drive interrupt
    // [RL19] drops when all cleared
    nxt_irq_n = ~(|(evt_in_ff & ~mask_in_ff) | |(evt_reg_ff & ~mask_reg_ff));
  end

  // Power-good is taken as present at reset so a missing rail flags at once.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      mask_in_ff          <= SSEI_RST_MASK;
      mask_reg_ff         <= SSEI_RST_MASK;
      ctrl_ff             <= SSEI_RST_CONTROL;
      evt_in_ff           <= 8'h00;
      evt_reg_ff          <= 8'h00;
      reg_rdata_ff        <= 8'h00;
      interrupt_out_n_ff  <= 1'b1;
      act_prev_ff         <= 5'h1f; // No false activation at reset.
      cond_prev_ff        <= SSEI_RST_COND;
      upper_wr_pulse_ff   <= 1'b0;
      upper_wr_ff         <= '0;
      upper_range_lock_ff <= 1'b0;
    end else if (clk_en) begin
      mask_in_ff          <= nxt_mask_in;
      mask_reg_ff         <= nxt_mask_reg;
      ctrl_ff             <= nxt_ctrl;
      evt_in_ff           <= nxt_evt_in;
      evt_reg_ff          <= nxt_evt_reg;
      reg_rdata_ff        <= nxt_rdata;
      interrupt_out_n_ff  <= nxt_irq_n;
      act_prev_ff         <= nxt_act_prev;
      cond_prev_ff        <= cond;
      upper_wr_pulse_ff   <= nxt_up_pulse;
      upper_wr_ff         <= nxt_upper_wr;
      upper_range_lock_ff <= nxt_ctrl[SSEI_POS_LOCK];
    end
  end

  // ==========================================================================
  // Debounce of the general inputs
  // ==========================================================================
  logic [13:0] tick_cnt_ff, nxt_tick_cnt, deb_lim;
  logic        deb_tick;

  // One shared 0.1 ms prescaler keeps five long counters out of the design.
  always_comb begin
    deb_tick     = tick_cnt_ff == 14'(DEB_TICK_CYC - 1);
    nxt_tick_cnt = deb_tick ? 14'h0000 : tick_cnt_ff + 14'h0001;
    // [RL17] debounce time select
    case (deb_code)
      3'h1:    deb_lim = SSEI_DEB_T1;
      3'h2:    deb_lim = SSEI_DEB_T2;
      3'h3:    deb_lim = SSEI_DEB_T3;
      3'h4:    deb_lim = SSEI_DEB_T4;
      3'h5:    deb_lim = SSEI_DEB_T5;
      3'h6:    deb_lim = SSEI_DEB_T6;
      3'h7:    deb_lim = SSEI_DEB_T7;
      default: deb_lim = 14'h0000;
    endcase
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      tick_cnt_ff <= 14'h0000;
    end else if (clk_en) begin
      tick_cnt_ff <= nxt_tick_cnt;
    end
  end

  // The first tick after a change may come early, so the time is met within one tick.
  for (genvar g = 0; g < 5; g++) begin : g_deb
    logic [13:0] cnt_ff, nxt_cnt;
    logic        nxt_deb;
    always_comb begin
      nxt_cnt = 14'h0000;
      nxt_deb = deb_ff[g];
      if (lvl_ff[g] != deb_ff[g]) begin
        if (deb_code == 3'h0 || (deb_tick && cnt_ff + 14'h0001 >= deb_lim)) begin
          nxt_deb = lvl_ff[g];
        end else begin
          nxt_cnt = cnt_ff + {13'h0000, deb_tick};
        end
      end
    end
    always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
        cnt_ff    <= 14'h0000;
        deb_ff[g] <= 1'b0;
      end else if (clk_en) begin
        cnt_ff    <= nxt_cnt;
        deb_ff[g] <= nxt_deb;
      end
    end
  end

  // ==========================================================================
  // Ramp step interval timers, one per buck
  // ==========================================================================
  for (genvar b = 0; b < 2; b++) begin : g_ramp
    logic [5:0] cnt_ff, nxt_cnt, lim;
    logic [1:0] code;
    logic       busy, nxt_tick;
    assign code = b ? ctrl_ff[SSEI_POS_SLEW_B +: 2] : ctrl_ff[SSEI_POS_SLEW_A +: 2];
    assign busy = b ? cond.ramp_busy_b : cond.ramp_busy_a;
    // Steps are only timed while the buck is ramping, so idle bucks stay quiet.
    always_comb begin
      // [RL15] buck B interval
      // [RL16] buck A interval
      case (code)
        2'h0:    lim = 6'(SSEI_STEP0_CYC);
        2'h1:    lim = 6'(SSEI_STEP1_CYC);
        2'h2:    lim = 6'(SSEI_STEP2_CYC);
        default: lim = 6'(SSEI_STEP3_CYC);
      endcase
      nxt_tick = busy && cnt_ff >= lim - 6'h01;
      nxt_cnt  = (!busy || nxt_tick) ? 6'h00 : cnt_ff + 6'h01;
    end
    always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
        cnt_ff               <= 6'h00;
        ramp_step_tick_ff[b] <= 1'b0;
      end else if (clk_en) begin
        cnt_ff               <= nxt_cnt;
        ramp_step_tick_ff[b] <= nxt_tick;
      end
    end
  end

endmodule // ssei_top

`default_nettype wire

/* testbench/ssei_host_model.sv */
// Host processor model issuing single-byte register accesses.
`timescale 1ns/100ps
`default_nettype none
module ssei_host_model (
  // Clock
  input  wire logic                clock,
  // Register access
  output var  ssei_pkg::ssei_req_s reg_req,
  input  wire logic [7:0]          reg_rdata_ff
);
  import ssei_pkg::*;
  // ==========================================================================
  // Access tasks, entered shortly after a rising edge
  // ==========================================================================
  initial reg_req = '0;
  // The strobe stands over one taking edge, then an idle edge; released lines show inverted values.
  task automatic access(input logic w, input logic [8:0] a, input logic [7:0] d, output logic [7:0] q);
    reg_req = '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clock);
    #10;
    q = reg_rdata_ff;
    reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    @(posedge clock);
    #10;
  endtask
  task automatic write(input logic [8:0] a, input logic [7:0] d);
    logic [7:0] q;
    access(1'b1, a, d, q);
  endtask
  task automatic read(input logic [8:0] a, output logic [7:0] q);
    access(1'b0, a, 8'h00, q);
  endtask
  task automatic clear(input logic [8:0] a);
    logic [7:0] q;
    read(a, q);
    write(a, q);
  endtask
endmodule // ssei_host_model
`default_nettype wire

/* testbench/ssei_top_asserts.sv */
// Concurrent checks on the ports of the status, event and interrupt block.
`timescale 1ns/100ps
`default_nettype none
module ssei_top_asserts #(
  parameter int DEB_TICK_CYC = 4
) (
  // Clock, reset and enable
  input wire logic                     clock,
  input wire logic                     nrst,
  input wire logic                     clk_en,
  // Observed ports
  input wire ssei_pkg::ssei_req_s      reg_req,
  input wire logic [7:0]               reg_rdata_ff,
  input wire logic                     interrupt_out_n_ff,
  input wire logic                     upper_range_lock_ff,
  input wire logic                     upper_wr_pulse_ff,
  input wire ssei_pkg::ssei_upper_wr_s upper_wr_ff,
  input wire logic [1:0]               ramp_step_tick_ff
);
  import ssei_pkg::*;
  logic upper_hit;
  logic rd_hit;
  logic in_all_ff;
  logic reg_all_ff;
  logic nxt_in_all;
  logic nxt_reg_all;
  // ==========================================================================
  // Helper logic: which mask registers were last written with every bit set
  // ==========================================================================
  assign upper_hit = clk_en && reg_req.wr && reg_req.addr >= SSEI_LOCK_LO && reg_req.addr <= SSEI_LOCK_HI;
  assign rd_hit    = clk_en && reg_req.rd;
  // Shadow of the masks, so the interrupt can be tied to them.
  always_comb begin
    nxt_in_all  = in_all_ff;
    nxt_reg_all = reg_all_ff;
    if (clk_en && reg_req.wr && reg_req.addr == SSEI_ADDR_MASK_IN) begin
      nxt_in_all = (reg_req.wdata & SSEI_IN_EVT_BITS) == SSEI_IN_EVT_BITS;
    end
    if (clk_en && reg_req.wr && reg_req.addr == SSEI_ADDR_MASK_REG) begin
      nxt_reg_all = (reg_req.wdata & SSEI_REG_EVT_BITS) == SSEI_REG_EVT_BITS;
    end
  end
  // Masks reset to zero, so the shadow starts as not all masked.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      in_all_ff  <= 1'b0;
      reg_all_ff <= 1'b0;
    end else begin
      in_all_ff  <= nxt_in_all;
      reg_all_ff <= nxt_reg_all;
    end
  end
  // ==========================================================================
  // Properties
  // ==========================================================================
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  sequence s_open_wr;
    upper_hit && !upper_range_lock_ff;
  endsequence
  sequence s_passed_on;
    upper_wr_pulse_ff && upper_wr_ff == {$past(reg_req.addr), $past(reg_req.wdata)};
  endsequence
  a_upper_wr_pass:
    assert property (s_open_wr |=> s_passed_on) else $error("permitted upper write not passed on");
  a_lock_blocks_wr:
    assert property (upper_hit && upper_range_lock_ff |=> !upper_wr_pulse_ff) else $error("locked write passed");
  a_pulse_has_cause:
    assert property (upper_wr_pulse_ff |-> $past(upper_hit && !upper_range_lock_ff)) else $error("stray pulse");
  a_lock_bit_copy:
    assert property (clk_en && reg_req.wr && reg_req.addr == SSEI_ADDR_CONTROL
      |=> upper_range_lock_ff == $past(reg_req.wdata[SSEI_POS_LOCK])) else $error("lock copy wrong");
  a_resv_in_zero:
    assert property (rd_hit && (reg_req.addr == SSEI_ADDR_EVENT_IN || reg_req.addr == SSEI_ADDR_MASK_IN)
      |=> (reg_rdata_ff & ~SSEI_IN_EVT_BITS) == 8'h00) else $error("reserved input bits set");
  a_resv_reg_zero:
    assert property (rd_hit && (reg_req.addr == SSEI_ADDR_EVENT_REG || reg_req.addr == SSEI_ADDR_MASK_REG)
      |=> (reg_rdata_ff & ~SSEI_REG_EVT_BITS) == 8'h00) else $error("reserved regulator bits set");
  a_unmapped_zero:
    assert property (rd_hit && (reg_req.addr < SSEI_ADDR_STATUS_IN || reg_req.addr > SSEI_ADDR_CONTROL)
      |=> reg_rdata_ff == 8'h00) else $error("unmapped read not zero");
  a_masked_no_irq:
    assert property (in_all_ff && reg_all_ff && $past(in_all_ff && reg_all_ff) |-> interrupt_out_n_ff)
      else $error("interrupt while all masked");
  a_step_gap_a:
    assert property (ramp_step_tick_ff[0] |=> !ramp_step_tick_ff[0] [*4]) else $error("buck a steps too close");
  a_step_gap_b:
    assert property (ramp_step_tick_ff[1] |=> !ramp_step_tick_ff[1] [*4]) else $error("buck b steps too close");
endmodule // ssei_top_asserts
bind ssei_top ssei_top_asserts #(.DEB_TICK_CYC(DEB_TICK_CYC)) u_chk (.clock(clock), .nrst(nrst), .clk_en(clk_en),
  .reg_req(reg_req), .reg_rdata_ff(reg_rdata_ff), .interrupt_out_n_ff(interrupt_out_n_ff),
  .upper_range_lock_ff(upper_range_lock_ff), .upper_wr_pulse_ff(upper_wr_pulse_ff),
  .upper_wr_ff(upper_wr_ff), .ramp_step_tick_ff(ramp_step_tick_ff));
`default_nettype wire

/* testbench/tb.sv */
// Self-checking bench for the status, event and interrupt block.
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e, m) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
  $display("wrong value at %0t: %s got %h exp %h", $time, m, g, e); end end
module tb;
  import ssei_pkg::*;
  localparam int TICK = 4;
  logic           clock;
  logic           nrst;
  logic           clk_en;
  ssei_req_s      reg_req;
  logic [7:0]     reg_rdata_ff;
  logic [4:0]     general_input;
  ssei_cond_s     cond_in;
  logic [4:0]     input_polarity_select;
  logic           interrupt_out_n_ff;
  logic           upper_range_lock_ff;
  logic           upper_wr_pulse_ff;
  ssei_upper_wr_s upper_wr_ff;
  logic [1:0]     ramp_step_tick_ff;
  int             n_fail;
  int             n_compared;
  int             lat;
  int             n_wait;
  int             n_pulse = 0;
  int             steps [4] = '{SSEI_STEP0_CYC, SSEI_STEP1_CYC, SSEI_STEP2_CYC, SSEI_STEP3_CYC};
  ssei_host_model host (.clock(clock), .reg_req(reg_req), .reg_rdata_ff(reg_rdata_ff));
  ssei_top #(.DEB_TICK_CYC(TICK)) uut (.clock(clock), .nrst(nrst), .clk_en(clk_en), .reg_req(reg_req),
    .reg_rdata_ff(reg_rdata_ff), .general_input(general_input), .cond_in(cond_in),
    .input_polarity_select(input_polarity_select), .interrupt_out_n_ff(interrupt_out_n_ff),
    .upper_range_lock_ff(upper_range_lock_ff), .upper_wr_pulse_ff(upper_wr_pulse_ff),
    .upper_wr_ff(upper_wr_ff), .ramp_step_tick_ff(ramp_step_tick_ff));
  // ==========================================================================
  // Clock and helper tasks
  // ==========================================================================
  // Free-running 10 MHz clock.
  always #50 clock = ~clock;
  // Counts upper-range strobes, which stand for one cycle only.
  always @(posedge clock) n_pulse <= n_pulse + int'(upper_wr_pulse_ff);
  task automatic end_sim();
    $display("counts: %0d compared, %0d wrong", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #10;
  endtask
  task automatic rd_chk(input logic [8:0] a, input logic [7:0] e);
    logic [7:0] q;
    host.read(a, q);
    `CHK(q, e, "read data")
  endtask
  task automatic give_up(input string m);
    n_fail++;
    $display("wrong value at %0t: %s wait ran out", $time, m);
    end_sim();
  endtask
  // Counts cycles until the interrupt reaches the level wanted.
  task automatic wait_irq(input logic e, output int n);
    for (n = 0; interrupt_out_n_ff !== e; n++) begin
      if (n > 200) give_up("interrupt");
      cyc(1);
    end
  endtask
  // Measures the gap between two step pulses of one buck; a missing pulse ends the run.
  task automatic tick_gap(input int b, input int e);
    int n;
    for (n = 0; ramp_step_tick_ff[b] !== 1'b1; n++) begin
      if (n > 200) give_up("step");
      cyc(1);
    end
    cyc(1);
    for (n = 1; ramp_step_tick_ff[b] !== 1'b1; n++) begin
      if (n > 200) give_up("step");
      cyc(1);
    end
    `CHK(n, e, "step gap")
  endtask
  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    clock = 1'b0;
    nrst = 1'b0;
    clk_en = 1'b1;
    general_input = 5'h03;
    input_polarity_select = 5'h1c;
    cond_in = '0;
    cond_in.output_in_range_a = 1'b1;
    cond_in.output_in_range_b = 1'b1;
    n_fail = 0;
    n_compared = 0;
    repeat (6) @(posedge clock);
    #10 nrst = 1'b1;
    cyc(10);
    for (logic [8:0] a = 9'h052; a <= 9'h058; a++) rd_chk(a, 8'h00);
    rd_chk(SSEI_ADDR_STATUS_IN, 8'h03);
    `CHK(interrupt_out_n_ff, 1'b1, "irq after reset")
    $display("test reset done");
    host.write(SSEI_ADDR_MASK_IN, 8'hff);
    host.write(SSEI_ADDR_MASK_REG, 8'hff);
    host.write(SSEI_ADDR_STATUS_IN, 8'hff);
    rd_chk(SSEI_ADDR_MASK_IN, 8'h5f);
    rd_chk(SSEI_ADDR_MASK_REG, 8'h3f);
    rd_chk(SSEI_ADDR_STATUS_IN, 8'h03);
    general_input = 5'h14;
    cyc(10);
    rd_chk(SSEI_ADDR_STATUS_IN, 8'h14);
    rd_chk(SSEI_ADDR_EVENT_IN, 8'h17);
    `CHK(interrupt_out_n_ff, 1'b1, "masked irq")
    host.write(SSEI_ADDR_MASK_IN, 8'h00);
    wait_irq(1'b0, lat);
    host.clear(SSEI_ADDR_EVENT_IN);
    wait_irq(1'b1, lat);
    rd_chk(SSEI_ADDR_EVENT_IN, 8'h00);
    $display("test input events done");
    cond_in = '{ramp_busy_b: 1'b1, current_limit_hit_b: 1'b1, thermal_shutdown_flag: 1'b1,
                output_in_range_b: 1'b1, io_supply_undervoltage: 1'b1, default: 1'b0};
    cyc(10);
    rd_chk(SSEI_ADDR_STATUS_REG, 8'h6a);
    rd_chk(SSEI_ADDR_EVENT_REG, 8'h29);
    rd_chk(SSEI_ADDR_EVENT_IN, 8'h40);
    host.write(SSEI_ADDR_MASK_IN, 8'h40);
    wait_irq(1'b1, lat);
    host.write(SSEI_ADDR_MASK_REG, 8'h00);
    wait_irq(1'b0, lat);
    host.clear(SSEI_ADDR_EVENT_REG);
    host.clear(SSEI_ADDR_EVENT_IN);
    wait_irq(1'b1, lat);
    cond_in = '{output_in_range_a: 1'b1, output_in_range_b: 1'b1, default: 1'b0};
    cyc(10);
    rd_chk(SSEI_ADDR_EVENT_REG, 8'h00);
    $display("test regulator events done");
    // The write-back is timed to land on the same edge as a fresh event.
    cond_in.thermal_warning_flag = 1'b1;
    wait_irq(1'b0, lat);
    cond_in.thermal_warning_flag = 1'b0;
    host.clear(SSEI_ADDR_EVENT_REG);
    wait_irq(1'b1, n_wait);
    cond_in.thermal_warning_flag = 1'b1;
    cyc(lat - 2);
    host.write(SSEI_ADDR_EVENT_REG, 8'h04);
    rd_chk(SSEI_ADDR_EVENT_REG, 8'h04);
    cond_in.thermal_warning_flag = 1'b0;
    host.clear(SSEI_ADDR_EVENT_REG);
    $display("test late event done");
    host.write(SSEI_ADDR_CONTROL, 8'h80);
    rd_chk(SSEI_ADDR_CONTROL, 8'h80);
    `CHK(upper_range_lock_ff, 1'b1, "lock")
    host.write(SSEI_LOCK_LO, 8'h11);
    `CHK(n_pulse, 0, "locked write")
    host.write(SSEI_ADDR_CONTROL, 8'h00);
    host.write(SSEI_LOCK_HI, 8'h5a);
    `CHK(n_pulse, 1, "open write")
    `CHK(upper_wr_ff, {SSEI_LOCK_HI, 8'h5a}, "open write data")
    host.write(9'h0cf, 8'h01);
    `CHK(n_pulse, 1, "below range")
    $display("test lock done");
    cond_in.ramp_busy_a = 1'b1;
    cond_in.ramp_busy_b = 1'b1;
    for (int c = 0; c < 4; c++) begin
      host.write(SSEI_ADDR_CONTROL, {1'b0, 2'(c), 2'(c), 3'h0});
      tick_gap(0, steps[c]);
      tick_gap(1, steps[c]);
    end
    cond_in.ramp_busy_a = 1'b0;
    cond_in.ramp_busy_b = 1'b0;
    $display("test slew done");
    host.write(SSEI_ADDR_CONTROL, 8'h02);
    general_input = 5'h1c;
    cyc(30);
    rd_chk(SSEI_ADDR_EVENT_IN, 8'h00);
    cyc(30);
    rd_chk(SSEI_ADDR_EVENT_IN, 8'h08);
    $display("test debounce done");
    end_sim();
  end
endmodule // tb
`default_nettype wire
